// ---- include/xfer_pkg.sv ----
/*
 * Shared constants of the interrupt-driven transfer engine: register offsets,
 * reset values, transfer-information field positions and mode codes.
 * Assumes a 32-bit AHB-Lite register bus and a 32-bit memory master port.
 */

package xfer_pkg;

   // =====================================================================
   // Register offsets (byte addresses) and reset values
   // =====================================================================
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_VTB = 8'h04;
   localparam logic [7:0] OFF_ITB = 8'h08;
   localparam logic [7:0] OFF_SEQ = 8'h0C;
   localparam logic [7:0] OFF_DISP = 8'h10;
   localparam logic [7:0] OFF_STAT = 8'h14;
   localparam logic [31:0] REG_RESET = 32'h0000_0000;

   // =====================================================================
   // Control and sequence bit positions
   // =====================================================================
   localparam int CTRL_STOP_BIT = 0;
   localparam int CTRL_RSKIP_BIT = 1;
   localparam int CTRL_SHORT_BIT = 2;
   localparam int SEQ_EN_BIT = 8;

   // =====================================================================
   // Transfer information word 0 fields
   // =====================================================================
   localparam int MA_MODE = 30;
   localparam int MA_SZ = 28;
   localparam int MA_SM = 26;
   localparam int MA_WBD = 25;
   localparam int MA_DISP = 24;
   localparam int MB_CHNE = 23;
   localparam int MB_CHNS = 22;
   localparam int MB_DISEL = 21;
   localparam int MB_DTS = 20;
   localparam int MB_DM = 18;
   localparam int MB_SEQUENCE_END_FLAG = 17;
   localparam int MB_INDEX_TABLE_USE = 16;
   localparam int MC_PASS = 8;

   // =====================================================================
   // Codes
   // =====================================================================
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_REPEAT = 2'h1;
   localparam logic [1:0] MODE_BLOCK = 2'h2;
   localparam logic [1:0] AM_INC = 2'h2;
   localparam logic [1:0] AM_DEC = 2'h3;
   localparam logic [1:0] SZ_LONG = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic [1:0] PASS_ALSO = 2'h1;
   localparam logic [1:0] PASS_ONLY = 2'h2;
   localparam logic [1:0] LAST_INFO_WORD = 2'h3;
   localparam logic [31:0] INFO_STRIDE = 32'h0000_0010;
   localparam logic [31:0] SHORT_LOW_MASK = 32'h007F_FFFF;
   localparam logic [31:0] SHORT_HIGH_BASE = 32'hFF80_0000;

endpackage : xfer_pkg

// ---- rtl/xfer_regs.sv ----
/*
 * AHB-Lite register slave of the transfer engine, zero wait states.
 * Assumes one master, whole-word single transfers and a shared clock.
 */
`timescale 1ns/1ps
`default_nettype none

module xfer_regs (
   // Clock, reset, freeze
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Engine side
   input wire logic [31:0] status,
   output logic [31:0] ctrl,
   output logic [31:0] vtb,
   output logic [31:0] itb,
   output logic [31:0] seqr,
   output logic [31:0] disp,
   output logic cfg_wr
);

   // =====================================================================
   // Decode
   // =====================================================================
   wire logic take = hsel && htrans[1] && hready;
   logic wr_pend;
   logic [7:0] wr_off;
   logic [31:0] rd_mux;

   always_comb begin
      if (haddr == xfer_pkg::OFF_CTRL) rd_mux = ctrl;
      else if (haddr == xfer_pkg::OFF_VTB) rd_mux = vtb;
      else if (haddr == xfer_pkg::OFF_ITB) rd_mux = itb;
      else if (haddr == xfer_pkg::OFF_SEQ) rd_mux = seqr;
      else if (haddr == xfer_pkg::OFF_DISP) rd_mux = disp;
      else if (haddr == xfer_pkg::OFF_STAT) rd_mux = status;
      else rd_mux = 32'h0;
   end

   // =====================================================================
   // Registers
   // =====================================================================
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         hrdata <= 32'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend <= 1'b0;
         wr_off <= 8'h0;
         ctrl <= xfer_pkg::REG_RESET;
         vtb <= xfer_pkg::REG_RESET;
         itb <= xfer_pkg::REG_RESET;
         seqr <= xfer_pkg::REG_RESET;
         disp <= xfer_pkg::REG_RESET;
         cfg_wr <= 1'b0;
      end else if (ce) begin
         cfg_wr <= 1'b0;
         wr_pend <= take && hwrite && (hsize == xfer_pkg::HSIZE_WORD);
         if (take) begin
            wr_off <= haddr;
            hrdata <= hwrite ? 32'h0 : rd_mux;
         end
         if (wr_pend) begin
            cfg_wr <= 1'b1;
            if (wr_off == xfer_pkg::OFF_CTRL) ctrl <= hwdata;
            else if (wr_off == xfer_pkg::OFF_VTB) vtb <= hwdata;
            else if (wr_off == xfer_pkg::OFF_ITB) itb <= hwdata;
            else if (wr_off == xfer_pkg::OFF_SEQ) seqr <= hwdata;
            else if (wr_off == xfer_pkg::OFF_DISP) disp <= hwdata;
         end
      end
   end

endmodule : xfer_regs

`default_nettype wire

// ---- rtl/xfer_engine.sv ----
/*
 * Interrupt-driven transfer engine: fetches per-source transfer information
 * from memory and moves data in normal, repeat, block, chain and sequence
 * fashion. Assumes a memory port that answers each request with MEM_ACK and
 * an interrupt controller that holds ACT_REQ until ACT_ACK.
 */
`timescale 1ns/1ps
`default_nettype none

module xfer_engine (
   // Clock, reset, freeze
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic CE,
   // AHB-Lite register slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // Activation from the interrupt controller
   input wire logic ACT_REQ,
   input wire logic [7:0] ACT_VEC,
   output logic ACT_ACK,
   // Memory master
   output logic MEM_REQ,
   output logic MEM_WRITE,
   output logic [31:0] MEM_ADDR,
   output logic [1:0] MEM_SIZE,
   output logic [31:0] MEM_WDATA,
   input wire logic [31:0] MEM_RDATA,
   input wire logic MEM_ACK,
   // CPU interrupt and event link
   output logic CPU_IRQ,
   output logic [7:0] CPU_IRQ_VEC,
   output logic EVT_PULSE
);

   // =====================================================================
   // State
   // =====================================================================
   typedef enum logic [3:0] {
      ST_IDLE, ST_VEC, ST_INFO, ST_GO, ST_DRD, ST_DWR, ST_WB, ST_IDX, ST_NEXT
   } state_e;

   state_e state;
   logic [7:0] vec;
   logic [7:0] held_vec;
   logic [7:0] seq_idx;
   logic [31:0] info_addr;
   logic [31:0] resume_addr;
   logic [31:0] info0;
   logic [31:0] src;
   logic [31:0] dst;
   logic [31:0] data;
   logic [15:0] cnt;
   logic [7:0] rsize;
   logic [7:0] rcnt;
   logic [8:0] units_left;
   logic [1:0] widx;
   logic held_valid;
   logic in_seq;
   logic seq_first;
   logic seq_paused;

   wire logic [31:0] ctrl;
   wire logic [31:0] vtb;
   wire logic [31:0] itb;
   wire logic [31:0] seqr;
   wire logic [31:0] disp;
   wire logic cfg_wr;

   // =====================================================================
   // Address arithmetic
   // =====================================================================
   function automatic logic [31:0] unit_step(input logic [1:0] sz);
      unit_step = 32'h1 << sz;
   endfunction : unit_step

   function automatic logic [31:0] advance(input logic [31:0] a, input logic [1:0] am,
                                          input logic [1:0] sz, input logic de,
                                          input logic [31:0] dv);
      if (am == xfer_pkg::AM_INC) advance = a + (de ? dv : unit_step(sz));
      else if (am == xfer_pkg::AM_DEC) advance = a - unit_step(sz);
      else advance = a;
   endfunction : advance

   // Returns the address to where it stood before n units were moved.
   function automatic logic [31:0] rewind(input logic [31:0] a, input logic [1:0] am,
                                         input logic [1:0] sz, input logic [8:0] n);
      logic [31:0] span;
      span = {23'h0, n} << sz;
      if (am == xfer_pkg::AM_INC) rewind = a - span;
      else if (am == xfer_pkg::AM_DEC) rewind = a + span;
      else rewind = a;
   endfunction : rewind

   function automatic logic [31:0] map_addr(input logic [31:0] a, input logic short_m);
      if (!short_m) map_addr = a;
      else if (a[23]) map_addr = xfer_pkg::SHORT_HIGH_BASE | (a & xfer_pkg::SHORT_LOW_MASK);
      else map_addr = a & xfer_pkg::SHORT_LOW_MASK;
   endfunction : map_addr

   // =====================================================================
   // Entry fields and derived values
   // =====================================================================
   wire logic [1:0] md = info0[xfer_pkg::MA_MODE +: 2];
   wire logic [1:0] sz = info0[xfer_pkg::MA_SZ +: 2];
   wire logic [1:0] sm = info0[xfer_pkg::MA_SM +: 2];
   wire logic [1:0] dm = info0[xfer_pkg::MB_DM +: 2];
   wire logic [1:0] pass = info0[xfer_pkg::MC_PASS +: 2];
   wire logic wbd = info0[xfer_pkg::MA_WBD];
   wire logic disp_en = info0[xfer_pkg::MA_DISP];
   wire logic chne = info0[xfer_pkg::MB_CHNE];
   wire logic chns = info0[xfer_pkg::MB_CHNS];
   wire logic disel = info0[xfer_pkg::MB_DISEL];
   wire logic dts = info0[xfer_pkg::MB_DTS];
   wire logic sequence_end_flag = info0[xfer_pkg::MB_SEQUENCE_END_FLAG];
   wire logic index_table_use = info0[xfer_pkg::MB_INDEX_TABLE_USE];

   wire logic stop = ctrl[xfer_pkg::CTRL_STOP_BIT];
   wire logic rskip = ctrl[xfer_pkg::CTRL_RSKIP_BIT];
   wire logic short_mode = ctrl[xfer_pkg::CTRL_SHORT_BIT];
   wire logic hit_seq = seqr[xfer_pkg::SEQ_EN_BIT] && (ACT_VEC == seqr[7:0]);
   wire logic can_skip = rskip && held_valid && (held_vec == ACT_VEC) && !hit_seq;
   wire logic [8:0] rsz9 = (rsize == 8'h0) ? 9'h100 : {1'b0, rsize};
   wire logic last_unit = (units_left == 9'h1);
   wire logic reload = ((md == xfer_pkg::MODE_REPEAT) && (rcnt == 8'h1)) ||
                       ((md == xfer_pkg::MODE_BLOCK) && last_unit);
   wire logic [31:0] src_adv = advance(src, sm, sz, disp_en, disp);
   wire logic [31:0] dst_adv = advance(dst, dm, sz, 1'b0, 32'h0);
   wire logic [31:0] src_nxt = (reload && !dts) ? rewind(src_adv, sm, sz, rsz9) : src_adv;
   wire logic [31:0] dst_nxt = (reload && dts) ? rewind(dst_adv, dm, sz, rsz9) : dst_adv;
   wire logic [15:0] cnt_nxt = ((md != xfer_pkg::MODE_BLOCK) || last_unit) ? cnt - 16'h1 : cnt;
   wire logic [7:0] rcnt_nxt = (md != xfer_pkg::MODE_REPEAT) ? rcnt :
                               (rcnt == 8'h1) ? rsize : rcnt - 8'h1;
   wire logic chain = chne && (!chns || (cnt == 16'h0));
   wire logic wb_need = (widx == 2'h1) ? sm[1] : (widx == 2'h2) ? dm[1] : 1'b1;
   wire logic [31:0] wb_data = (widx == 2'h1) ? src : (widx == 2'h2) ? dst :
                               {cnt, rsize, rcnt};
   wire logic [31:0] info_ptr = info_addr + {28'h0, widx, 2'h0};
   wire logic [31:0] next_entry = info_addr + xfer_pkg::INFO_STRIDE;
   wire logic [31:0] status = {16'h0, vec, 5'h0, held_valid, seq_paused, state != ST_IDLE};
   wire logic done = MEM_REQ && MEM_ACK;

   // =====================================================================
   // Memory request selection
   // =====================================================================
   wire logic mem_state = (state == ST_VEC) || (state == ST_INFO) || (state == ST_DRD) ||
                          (state == ST_DWR) || (state == ST_IDX) ||
                          ((state == ST_WB) && wb_need);
   wire logic op_write = (state == ST_DWR) || (state == ST_WB);
   wire logic [1:0] op_size = ((state == ST_DRD) || (state == ST_DWR)) ? sz : xfer_pkg::SZ_LONG;
   wire logic [31:0] op_wdata = (state == ST_DWR) ? data : wb_data;
   logic [31:0] op_raw;

   always_comb begin
      case (state)
         ST_VEC: op_raw = vtb + {22'h0, vec, 2'h0};
         ST_DRD: op_raw = src;
         ST_DWR: op_raw = dst;
         ST_IDX: op_raw = itb + {22'h0, seq_idx, 2'h0};
         default: op_raw = info_ptr;
      endcase
   end

   // =====================================================================
   // Register slave
   // =====================================================================
   xfer_regs u_regs (
      .clk(CLK),
      .rst_b(RST_B),
      .ce(CE),
      .hsel(HSEL),
      .haddr(HADDR[7:0]),
      .htrans(HTRANS),
      .hwrite(HWRITE),
      .hsize(HSIZE),
      .hwdata(HWDATA),
      .hready(HREADY),
      .hrdata(HRDATA),
      .hreadyout(HREADYOUT),
      .hresp(HRESP),
      .status(status),
      .ctrl(ctrl),
      .vtb(vtb),
      .itb(itb),
      .seqr(seqr),
      .disp(disp),
      .cfg_wr(cfg_wr)
   );

   // =====================================================================
   // Transfer sequencer
   // =====================================================================
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         state <= ST_IDLE;
         vec <= 8'h0;
         held_vec <= 8'h0;
         seq_idx <= 8'h0;
         info_addr <= 32'h0;
         resume_addr <= 32'h0;
         info0 <= 32'h0;
         src <= 32'h0;
         dst <= 32'h0;
         data <= 32'h0;
         cnt <= 16'h0;
         rsize <= 8'h0;
         rcnt <= 8'h0;
         units_left <= 9'h0;
         widx <= 2'h0;
         held_valid <= 1'b0;
         in_seq <= 1'b0;
         seq_first <= 1'b0;
         seq_paused <= 1'b0;
         ACT_ACK <= 1'b0;
         MEM_REQ <= 1'b0;
         MEM_WRITE <= 1'b0;
         MEM_ADDR <= 32'h0;
         MEM_SIZE <= 2'h0;
         MEM_WDATA <= 32'h0;
         CPU_IRQ <= 1'b0;
         CPU_IRQ_VEC <= 8'h0;
         EVT_PULSE <= 1'b0;
      end else if (CE) begin
         ACT_ACK <= 1'b0;
         CPU_IRQ <= 1'b0;
         EVT_PULSE <= 1'b0;
         if (done) begin
            MEM_REQ <= 1'b0;
         end else if (mem_state && !MEM_REQ) begin
            MEM_REQ <= 1'b1;
            MEM_WRITE <= op_write;
            MEM_ADDR <= map_addr(op_raw, short_mode);
            MEM_SIZE <= op_size;
            MEM_WDATA <= op_wdata;
         end
         case (state)
            ST_IDLE: begin
               if (ACT_REQ && !stop) begin
                  ACT_ACK <= 1'b1;
                  vec <= ACT_VEC;
                  in_seq <= hit_seq;
                  widx <= 2'h0;
                  if (hit_seq && seq_paused) begin
                     seq_paused <= 1'b0;
                     seq_first <= 1'b0;
                     info_addr <= resume_addr;
                     state <= ST_INFO;
                  end else if (can_skip) begin
                     state <= ST_GO;
                  end else begin
                     seq_first <= hit_seq;
                     state <= ST_VEC;
                  end
               end
            end
            ST_VEC: begin
               if (done) begin
                  info_addr <= MEM_RDATA;
                  state <= ST_INFO;
               end
            end
            ST_INFO: begin
               if (done) begin
                  case (widx)
                     2'h0: info0 <= MEM_RDATA;
                     2'h1: src <= MEM_RDATA;
                     2'h2: dst <= MEM_RDATA;
                     default: {cnt, rsize, rcnt} <= MEM_RDATA;
                  endcase
                  widx <= widx + 2'h1;
                  if (widx == xfer_pkg::LAST_INFO_WORD) state <= ST_GO;
               end
            end
            ST_GO: begin
               units_left <= (md == xfer_pkg::MODE_BLOCK) ? rsz9 : 9'h1;
               held_valid <= !in_seq;
               held_vec <= vec;
               if (pass == xfer_pkg::PASS_ONLY) begin
                  CPU_IRQ <= 1'b1;
                  CPU_IRQ_VEC <= vec;
                  state <= ST_IDLE;
               end else begin
                  state <= ST_DRD;
               end
            end
            ST_DRD: begin
               if (done) begin
                  data <= MEM_RDATA;
                  if (in_seq && seq_first) seq_idx <= MEM_RDATA[7:0];
                  state <= ST_DWR;
               end
            end
            ST_DWR: begin
               if (done) begin
                  src <= src_nxt;
                  dst <= dst_nxt;
                  cnt <= cnt_nxt;
                  rcnt <= rcnt_nxt;
                  units_left <= units_left - 9'h1;
                  EVT_PULSE <= (md != xfer_pkg::MODE_BLOCK) || last_unit;
                  if (disel) begin
                     CPU_IRQ <= 1'b1;
                     CPU_IRQ_VEC <= vec;
                  end
                  widx <= 2'h1;
                  if (!last_unit) state <= ST_DRD;
                  else if (wbd) state <= ST_NEXT;
                  else state <= ST_WB;
               end
            end
            ST_WB: begin
               if (!wb_need) begin
                  widx <= widx + 2'h1;
               end else if (done) begin
                  widx <= widx + 2'h1;
                  if (widx == xfer_pkg::LAST_INFO_WORD) state <= ST_NEXT;
               end
            end
            ST_IDX: begin
               if (done) begin
                  info_addr <= MEM_RDATA;
                  state <= ST_INFO;
               end
            end
            ST_NEXT: begin
               widx <= 2'h0;
               if (in_seq && seq_first) begin
                  seq_first <= 1'b0;
                  if (index_table_use) state <= ST_IDX;
                  else begin
                     info_addr <= next_entry;
                     state <= ST_INFO;
                  end
               end else if (in_seq && !sequence_end_flag && !chne) begin
                  resume_addr <= next_entry;
                  seq_paused <= 1'b1;
                  state <= ST_IDLE;
               end else if ((in_seq && !sequence_end_flag) || (!in_seq && chain)) begin
                  held_valid <= 1'b0;
                  info_addr <= next_entry;
                  state <= ST_INFO;
               end else begin
                  if ((cnt == 16'h0) || (pass == xfer_pkg::PASS_ALSO)) begin
                     CPU_IRQ <= 1'b1;
                     CPU_IRQ_VEC <= vec;
                  end
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
         // Any register write may move tables, so held information is dropped.
         if (cfg_wr) held_valid <= 1'b0;
      end
   end

endmodule : xfer_engine

`default_nettype wire

// ---- verification/xfer_engine_properties.sv ----
/* Concurrent checks on the activation, memory and event ports of the engine.
   Assumes it is bound to the engine's top module. */
`timescale 1ns/1ps
`default_nettype none
module xfer_engine_properties (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // Watched ports
   input wire logic ACT_REQ,
   input wire logic ACT_ACK,
   input wire logic MEM_REQ,
   input wire logic MEM_WRITE,
   input wire logic MEM_ACK,
   input wire logic CPU_IRQ,
   input wire logic EVT_PULSE,
   input wire logic [31:0] MEM_ADDR,
   input wire logic [1:0] MEM_SIZE
);
   // ==========
   // Checks
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);
   chk_ack_cause: assert property (ACT_ACK |-> $past(ACT_REQ))
      else $error("ack without request");
   chk_ack_single: assert property (ACT_ACK |=> (!ACT_ACK) [*3])
      else $error("ack not a lone pulse");
   chk_first_read: assert property ($rose(ACT_ACK) |-> ##[0:8] (MEM_REQ && !MEM_WRITE))
      else $error("no read after activation");
   chk_req_hold: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR))
      else $error("memory request changed early");
   chk_req_drop: assert property (MEM_ACK |=> !MEM_REQ)
      else $error("request kept after answer");
   chk_size_legal: assert property (MEM_REQ |-> MEM_SIZE != 2'h3)
      else $error("illegal unit size");
   chk_long_align: assert property (MEM_REQ && MEM_SIZE == 2'h2 |-> MEM_ADDR[1:0] == 2'h0)
      else $error("longword not aligned");
   chk_evt_pulse: assert property (EVT_PULSE |=> !EVT_PULSE)
      else $error("event pulse too long");
   chk_irq_pulse: assert property (CPU_IRQ |=> !CPU_IRQ)
      else $error("irq pulse too long");
   cov_act: cover property (ACT_ACK);
   cov_evt: cover property (EVT_PULSE);
   cov_irq: cover property (CPU_IRQ);
endmodule : xfer_engine_properties
`default_nettype wire

// ---- verification/xfer_mem_model.sv ----
/* Word memory answering the engine's master port after 0 to 2 wait cycles.
   Assumes requests hold until the one-cycle answer. */
`timescale 1ns/1ps
`default_nettype none
module xfer_mem_model (
   // Clock
   input wire logic clk,
   // Request side
   input wire logic req,
   input wire logic wr,
   input wire logic [31:0] addr,
   input wire logic [31:0] wdata,
   output logic [31:0] rdata,
   output logic ack
);
   logic [31:0] m [bit [31:0]];
   int unsigned wait_n = 0;
   initial begin
      ack = 1'b0;
      rdata = 32'h0;
   end
   // Read data is scrambled every cycle outside a read answer.
   always @(posedge clk) begin
      ack <= 1'b0;
      rdata <= ~rdata;
      if (req && !ack) begin
         if (wait_n == 0) begin
            ack <= 1'b1;
            wait_n = $urandom_range(0, 2);
            if (wr) m[addr] = wdata;
            else rdata <= m.exists(addr) ? m[addr] : 32'h0;
         end else wait_n--;
      end
   end
endmodule : xfer_mem_model
`default_nettype wire

// ---- verification/interrupt_driven_transfer_engine_test.sv ----
/* Self-checking bench of the transfer engine.
   Assumes the memory model, the package and the property checker. */
`timescale 1ns/1ps
`default_nettype none
module interrupt_driven_transfer_engine_test;
   logic CLK = 0, RST_B = 0, HSEL = 0, HWRITE = 0, ACT_REQ = 0;
   logic [1:0] HTRANS = 0;
   logic [2:0] HSIZE = 0;
   logic [7:0] ACT_VEC = 0, CPU_IRQ_VEC;
   logic [31:0] HADDR = 0, HWDATA = 0, HRDATA, MEM_ADDR, MEM_WDATA, MEM_RDATA, rd, d;
   logic HREADYOUT, HRESP, ACT_ACK, MEM_REQ, MEM_WRITE, MEM_ACK, CPU_IRQ, EVT_PULSE;
   logic [1:0] MEM_SIZE;
   int fails = 0, n_compared = 0, n_evt = 0, n_irq = 0, n_ack = 0;
   logic [31:0] q [$];
   xfer_engine dut (.CLK(CLK), .RST_B(RST_B), .CE(1'b1), .HSEL(HSEL), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
      .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .ACT_REQ(ACT_REQ),
      .ACT_VEC(ACT_VEC), .ACT_ACK(ACT_ACK), .MEM_REQ(MEM_REQ), .MEM_WRITE(MEM_WRITE),
      .MEM_ADDR(MEM_ADDR), .MEM_SIZE(MEM_SIZE), .MEM_WDATA(MEM_WDATA),
      .MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK), .CPU_IRQ(CPU_IRQ),
      .CPU_IRQ_VEC(CPU_IRQ_VEC), .EVT_PULSE(EVT_PULSE));
   xfer_mem_model mem (.clk(CLK), .req(MEM_REQ), .wr(MEM_WRITE), .addr(MEM_ADDR),
      .wdata(MEM_WDATA), .rdata(MEM_RDATA), .ack(MEM_ACK));
   initial forever #2.5 CLK = ~CLK;
   always @(posedge CLK) begin
      n_evt += EVT_PULSE;
      n_irq += CPU_IRQ;
      n_ack += ACT_ACK;
   end
   // ==========
   // Tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      HSEL <= 1'b1;
      HTRANS <= 2'h2;
      HADDR <= {24'h0, a};
      HWRITE <= w;
      HSIZE <= xfer_pkg::HSIZE_WORD;
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= wd;
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
      rd = HRDATA;
   endtask : ahb
   task automatic act(input logic [7:0] v);
      ACT_REQ <= 1'b1;
      ACT_VEC <= v;
      do @(posedge CLK); while (ACT_ACK !== 1'b1);
      ACT_REQ <= 1'b0;
      do ahb(1'b0, xfer_pkg::OFF_STAT, 32'h0); while (rd[0] !== 1'b0);
   endtask : act
   task automatic info(input logic [31:0] p, w0, s, t, w3);
      mem.m[p] = w0;
      mem.m[p + 4] = s;
      mem.m[p + 8] = t;
      mem.m[p + 12] = w3;
   endtask : info
   task automatic close_out;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : close_out
   initial begin
      #100us;
      fails++;
      close_out();
   end
   initial begin
      void'($urandom(20137));
      repeat (4) @(posedge CLK);
      RST_B <= 1'b1;
      @(posedge CLK);
      ahb(1'b1, xfer_pkg::OFF_VTB, 32'h100);
      ahb(1'b0, xfer_pkg::OFF_VTB, 32'h0);
      check(rd, 32'h100);
      check(HRESP, 1'b0);
      ahb(1'b0, 8'h18, 32'h0);
      check(rd, 32'h0);
      for (int i = 0; i < 6; i++) q.push_back($urandom);
      foreach (q[i]) mem.m[32'h1000 + 4 * i] = q[i];
      for (int v = 3; v < 7; v++) mem.m[32'h100 + 4 * v] = 32'h100 * (v - 1);
      info(32'h200, 32'h2808_0000, 32'h1000, 32'h2000, 32'h0002_0000);
      info(32'h300, 32'hA808_0000, 32'h1008, 32'h2100, 32'h0001_0404);
      info(32'h400, 32'h2A08_0000, 32'h1004, 32'h2200, 32'h0005_0000);
      act(8'h03);
      check(mem.m[32'h2000], q[0]);
      check(mem.m[32'h204], 32'h1004);
      check(mem.m[32'h20C], 32'h0001_0000);
      check(n_evt, 1);
      act(8'h03);
      check(mem.m[32'h2004], q[1]);
      check(n_irq, 1);
      check(CPU_IRQ_VEC, 32'h3);
      act(8'h04);
      for (int i = 0; i < 4; i++) check(mem.m[32'h2100 + 4 * i], q[i + 2]);
      check(mem.m[32'h304], 32'h1008);
      check(mem.m[32'h308], 32'h2110);
      check(n_evt, 3);
      ahb(1'b1, xfer_pkg::OFF_CTRL, 32'h1);
      d = n_ack;
      ACT_REQ <= 1'b1;
      ACT_VEC <= 8'h05;
      repeat (20) @(posedge CLK);
      check(n_ack, d);
      ahb(1'b1, xfer_pkg::OFF_CTRL, 32'h0);
      act(8'h05);
      check(n_ack, d + 1);
      check(mem.m[32'h2200], q[1]);
      check(mem.m[32'h404], 32'h1004);
      check(mem.m[32'h40C], 32'h0005_0000);
      // Repeat entry: bytes, fixed source, destination side reloads after two units.
      info(32'h500, 32'h4038_0000, 32'h1000, 32'h2300, 32'h0005_0202);
      act(8'h06);
      check(mem.m[32'h508], 32'h2301);
      check(mem.m[32'h50C], 32'h0004_0201);
      mem.m[32'h504] = 32'h3000;
      act(8'h06);
      check(mem.m[32'h504], 32'h3000);
      check(mem.m[32'h508], 32'h2300);
      check(mem.m[32'h50C], 32'h0003_0202);
      check(n_evt, 6);
      check(n_irq, 4);
      check(CPU_IRQ_VEC, 32'h6);
      check(rd[15:8], 32'h6);
      close_out();
   end
endmodule : interrupt_driven_transfer_engine_test
bind xfer_engine xfer_engine_properties chk (.CLK(CLK), .RST_B(RST_B), .ACT_REQ(ACT_REQ),
   .ACT_ACK(ACT_ACK), .MEM_REQ(MEM_REQ), .MEM_WRITE(MEM_WRITE), .MEM_ACK(MEM_ACK),
   .CPU_IRQ(CPU_IRQ), .EVT_PULSE(EVT_PULSE), .MEM_ADDR(MEM_ADDR), .MEM_SIZE(MEM_SIZE));
`default_nettype wire
